// File: pkg/cti_pkg.sv
// Shared constants and types for the camera trigger and status line block.
package cti_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
    localparam int PRE_W = 5;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);
    localparam logic [PRE_W-1:0] PRE_RST = 5'h00;

    // ==========================================================
    // Setting widths and limits
    localparam int DLY_W = 23;
    localparam int DEB_W = 15;
    localparam logic [DLY_W-1:0] DELAY_MAX_US_DEF = 23'h4c4b40;
    localparam logic [DEB_W-1:0] DEBOUNCE_MAX_US_DEF = 15'h4e20;
    localparam logic [DLY_W-1:0] DLY_RST = 23'h000000;
    localparam logic [DEB_W-1:0] DEB_RST = 15'h0000;

    // ==========================================================
    // Reset levels
    localparam logic LEVEL_RST = 1'b0;
    localparam logic WAIT_RST = 1'b1;
    localparam logic OE_N_RST = 1'b1;

    // ==========================================================
    // Trigger source selection
    localparam logic [1:0] SRC_ISO = 2'h0;
    localparam logic [1:0] SRC_A = 2'h1;
    localparam logic [1:0] SRC_B = 2'h2;

    // User value bit that each output line drives.
    localparam int UBIT_ISO = 0;
    localparam int UBIT_A = 1;
    localparam int UBIT_B = 2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        OM_WAIT = 2'b00,
        OM_EXPO = 2'b01,
        OM_STROBE = 2'b10,
        OM_USER = 2'b11
    } cti_omode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_BUSY = 2'b10
    } cti_state_t;
endpackage

// File: design/cti_debounce.sv
// Debouncer that passes a level only after it has been stable for the set time.
`timescale 1ns/1ps
module cti_debounce #(
    parameter int CW = 15
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Timing
    input wire logic tick_us,
    input wire logic [CW-1:0] deb_us,
    // Levels
    input wire logic raw_in,
    output logic clean_out
);
    import cti_pkg::*;

    logic clean_ff;
    logic nxt_clean;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;

    // ==========================================================
    // Stability counter
    always_comb begin
        nxt_clean = clean_ff;
        nxt_cnt = cnt_ff;
        if (raw_in == clean_ff) begin
            nxt_cnt = '0;
        end else if (cnt_ff >= deb_us) begin
            nxt_clean = raw_in;
            nxt_cnt = '0;
        end else if (tick_us) begin
            nxt_cnt = cnt_ff + CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clean_ff <= LEVEL_RST;
            cnt_ff <= '0;
        end else begin
            clean_ff <= nxt_clean;
            cnt_ff <= nxt_cnt;
        end
    end

    assign clean_out = clean_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_deb_change_cause: assert property (
        $changed(clean_ff) |-> $past(raw_in) == clean_ff && $past(cnt_ff) >= $past(deb_us))
        else $error("Debounced level changed without a stable input.");
    a_deb_zero_pass: assert property (
        deb_us == '0 && raw_in != clean_ff |=> clean_ff == $past(raw_in))
        else $error("Zero debounce time did not pass the input at once.");
endmodule

// File: design/cti_top.sv
// Trigger input qualification, trigger delay and status output lines of the camera.
//
// Notes on behaviour
// - Trigger qualified on rising or falling edge.
// - Trigger delay settable zero to five seconds.
// - Wait full delay before starting capture.
// - Delay only applies to input-configured lines.
// - Output mode only applies to output lines.
// - Output picks wait, exposure, strobe or user.
// - Wait low at exposure, high after readout.
// - Triggers ignored while trigger wait is low.
// - Exposure output follows sensor exposing one cycle later.
// - Debounce each input, zero to twenty milliseconds.
// - Pulses shorter than debounce time are dropped.
// - Only general lines change direction; isolated fixed.
// - User level uses bit per line number.
`timescale 1ns/1ps
module cti_top #(
    parameter logic [cti_pkg::DLY_W-1:0] DELAY_MAX_US = cti_pkg::DELAY_MAX_US_DEF,
    parameter logic [cti_pkg::DEB_W-1:0] DEBOUNCE_MAX_US = cti_pkg::DEBOUNCE_MAX_US_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Isolated lines
    input wire logic iso_in,
    output logic iso_out,
    // General line a
    input wire logic general_line_a_in,
    output logic general_line_a_out,
    output logic general_line_a_oe_n,
    // General line b
    input wire logic general_line_b_in,
    output logic general_line_b_out,
    output logic general_line_b_oe_n,
    // Line configuration
    input wire logic dir_out_a,
    input wire logic dir_out_b,
    input wire logic [1:0] trig_src_sel,
    input wire logic edge_falling,
    input wire logic [cti_pkg::DEB_W-1:0] debounce_us,
    input wire logic [cti_pkg::DLY_W-1:0] delay_us,
    input wire cti_pkg::cti_omode_t out_mode_iso,
    input wire cti_pkg::cti_omode_t out_mode_a,
    input wire cti_pkg::cti_omode_t out_mode_b,
    input wire logic [2:0] user_value,
    // Sensor side
    input wire logic sensor_exposing,
    input wire logic readout_done,
    input wire logic strobe_in,
    output logic capture_start,
    // Status
    output logic trig_wait,
    output logic exposure_active,
    output logic trig_ignored,
    output logic delay_busy
);
    import cti_pkg::*;

    // ==========================================================
    // Microsecond prescaler
    logic [PRE_W-1:0] pre_ff;
    logic [PRE_W-1:0] nxt_pre;
    logic tick_us;

    always_comb begin
        tick_us = (pre_ff == PRE_LAST);
        nxt_pre = tick_us ? PRE_RST : pre_ff + PRE_W'(1);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pre_ff <= PRE_RST;
        end else begin
            pre_ff <= nxt_pre;
        end
    end

    // ==========================================================
    // Debouncing of the three input-capable lines
    logic [DEB_W-1:0] deb_eff;
    logic clean_iso;
    logic clean_a;
    logic clean_b;

    assign deb_eff = (debounce_us > DEBOUNCE_MAX_US) ? DEBOUNCE_MAX_US : debounce_us;

    cti_debounce #(.CW(DEB_W)) u_deb_iso (
        .core_clk(core_clk),
        .rst(rst),
        .tick_us(tick_us),
        .deb_us(deb_eff),
        .raw_in(iso_in),
        .clean_out(clean_iso)
    );

    cti_debounce #(.CW(DEB_W)) u_deb_a (
        .core_clk(core_clk),
        .rst(rst),
        .tick_us(tick_us),
        .deb_us(deb_eff),
        .raw_in(general_line_a_in),
        .clean_out(clean_a)
    );

    cti_debounce #(.CW(DEB_W)) u_deb_b (
        .core_clk(core_clk),
        .rst(rst),
        .tick_us(tick_us),
        .deb_us(deb_eff),
        .raw_in(general_line_b_in),
        .clean_out(clean_b)
    );

    // ==========================================================
    // Source selection and edge qualification
    logic src_level;
    logic src_valid;
    logic prev_ff;
    logic trig_edge;

    always_comb begin
        src_level = LEVEL_RST;
        src_valid = 1'b0;
        case (trig_src_sel)
            SRC_ISO: begin
                src_level = clean_iso;
                src_valid = 1'b1;
            end
            SRC_A: begin
                src_level = clean_a;
                src_valid = !dir_out_a;
            end
            SRC_B: begin
                src_level = clean_b;
                src_valid = !dir_out_b;
            end
            default: begin
                src_valid = 1'b0;
            end
        endcase
        trig_edge = src_valid && (edge_falling ? (prev_ff && !src_level)
                                               : (!prev_ff && src_level));
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prev_ff <= LEVEL_RST;
        end else begin
            prev_ff <= src_level;
        end
    end

    // ==========================================================
    // Trigger delay and frame sequencing
    cti_state_t state_ff;
    cti_state_t nxt_state;
    logic [PRE_W-1:0] sub_ff;
    logic [PRE_W-1:0] nxt_sub;
    logic [DLY_W-1:0] us_ff;
    logic [DLY_W-1:0] nxt_us;
    logic [DLY_W-1:0] lat_ff;
    logic [DLY_W-1:0] nxt_lat;
    logic [DLY_W-1:0] delay_eff;
    logic go;
    logic ignore_now;

    assign delay_eff = (delay_us > DELAY_MAX_US) ? DELAY_MAX_US : delay_us;

    always_comb begin
        nxt_state = state_ff;
        nxt_sub = sub_ff;
        nxt_us = us_ff;
        nxt_lat = lat_ff;
        go = 1'b0;
        ignore_now = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (trig_edge) begin
                    nxt_lat = delay_eff;
                    nxt_sub = PRE_RST;
                    nxt_us = DLY_RST;
                    nxt_state = ST_DELAY;
                end
            end
            ST_DELAY: begin
                ignore_now = trig_edge;
                if (us_ff == lat_ff) begin
                    go = 1'b1;
                    nxt_state = ST_BUSY;
                end else if (sub_ff == PRE_LAST) begin
                    nxt_sub = PRE_RST;
                    nxt_us = us_ff + DLY_W'(1);
                end else begin
                    nxt_sub = sub_ff + PRE_W'(1);
                end
            end
            ST_BUSY: begin
                ignore_now = trig_edge;
                if (readout_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            sub_ff <= PRE_RST;
            us_ff <= DLY_RST;
            lat_ff <= DLY_RST;
        end else begin
            state_ff <= nxt_state;
            sub_ff <= nxt_sub;
            us_ff <= nxt_us;
            lat_ff <= nxt_lat;
        end
    end

    // ==========================================================
    // Status and output lines
    logic nxt_wait;
    logic wait_ff;
    logic expo_ff;
    logic start_ff;
    logic ign_ff;
    logic dbusy_ff;
    logic iso_out_ff;
    logic a_out_ff;
    logic a_oe_n_ff;
    logic b_out_ff;
    logic b_oe_n_ff;
    logic nxt_iso_out;
    logic nxt_a_out;
    logic nxt_b_out;

    function automatic logic pick(cti_omode_t m, logic ubit, logic w, logic e, logic s);
        logic r;
        case (m)
            OM_WAIT: r = w;
            OM_EXPO: r = e;
            OM_STROBE: r = s;
            OM_USER: r = ubit;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    always_comb begin
        nxt_wait = (nxt_state != ST_BUSY);
        nxt_iso_out = pick(out_mode_iso, user_value[UBIT_ISO], nxt_wait,
                           sensor_exposing, strobe_in);
        nxt_a_out = dir_out_a ? pick(out_mode_a, user_value[UBIT_A], nxt_wait,
                                     sensor_exposing, strobe_in) : LEVEL_RST;
        nxt_b_out = dir_out_b ? pick(out_mode_b, user_value[UBIT_B], nxt_wait,
                                     sensor_exposing, strobe_in) : LEVEL_RST;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wait_ff <= WAIT_RST;
            expo_ff <= LEVEL_RST;
            start_ff <= LEVEL_RST;
            ign_ff <= LEVEL_RST;
            dbusy_ff <= LEVEL_RST;
            iso_out_ff <= LEVEL_RST;
            a_out_ff <= LEVEL_RST;
            a_oe_n_ff <= OE_N_RST;
            b_out_ff <= LEVEL_RST;
            b_oe_n_ff <= OE_N_RST;
        end else begin
            wait_ff <= nxt_wait;
            expo_ff <= sensor_exposing;
            start_ff <= go;
            ign_ff <= ignore_now;
            dbusy_ff <= (nxt_state == ST_DELAY);
            iso_out_ff <= nxt_iso_out;
            a_out_ff <= nxt_a_out;
            a_oe_n_ff <= !dir_out_a;
            b_out_ff <= nxt_b_out;
            b_oe_n_ff <= !dir_out_b;
        end
    end

    assign trig_wait = wait_ff;
    assign exposure_active = expo_ff;
    assign capture_start = start_ff;
    assign trig_ignored = ign_ff;
    assign delay_busy = dbusy_ff;
    assign iso_out = iso_out_ff;
    assign general_line_a_out = a_out_ff;
    assign general_line_a_oe_n = a_oe_n_ff;
    assign general_line_b_out = b_out_ff;
    assign general_line_b_oe_n = b_oe_n_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_edge_arms_delay: assert property (
        state_ff == ST_IDLE && trig_edge |=> state_ff == ST_DELAY && us_ff == '0)
        else $error("Qualified edge did not start the delay.");
    a_delay_full: assert property (
        go |-> state_ff == ST_DELAY && us_ff == lat_ff && sub_ff == PRE_RST)
        else $error("Capture started before the delay ran out.");
    a_delay_clamped: assert property (
        lat_ff <= DELAY_MAX_US)
        else $error("Latched delay exceeds the limit.");
    a_invalid_src: assert property (
        !src_valid |-> !trig_edge)
        else $error("Edge taken from a line set as output.");
    a_wait_low_start: assert property (
        start_ff |-> !wait_ff ##1 !start_ff)
        else $error("Trigger wait not low at exposure start.");
    a_wait_high_done: assert property (
        state_ff == ST_BUSY && readout_done |=> wait_ff && state_ff == ST_IDLE)
        else $error("Trigger wait did not return after readout.");
    a_ignore_busy: assert property (
        state_ff == ST_BUSY && trig_edge && !readout_done |=> ign_ff && state_ff == ST_BUSY)
        else $error("Trigger taken while trigger wait was low.");
    a_expo_follow: assert property (
        ##1 expo_ff == $past(sensor_exposing))
        else $error("Exposure output does not track the sensor.");
    a_input_line_off: assert property (
        !dir_out_a |=> a_oe_n_ff && !a_out_ff)
        else $error("General line a driven while set as input.");
    a_user_bit: assert property (
        dir_out_b && out_mode_b == OM_USER |=> b_out_ff == $past(user_value[UBIT_B]))
        else $error("User level on line b uses the wrong bit.");
    a_iso_wait_mode: assert property (
        out_mode_iso == OM_WAIT |=> iso_out_ff == wait_ff)
        else $error("Isolated output does not show trigger wait.");

    c_capture: cover property (state_ff == ST_DELAY ##1 start_ff);
    c_ignored: cover property (ign_ff);
    c_frame_done: cover property (start_ff ##[1:200] wait_ff);
    c_long_delay: cover property (go && lat_ff > 23'h000002);
endmodule

// File: dv/cti_trig_src.sv
// Model of the external equipment that pulses one of the three trigger lines.
`timescale 1ns/1ps
module cti_trig_src (
    // Clock
    input wire logic core_clk,
    // Requests from the bench
    input wire logic go,
    input wire logic [1:0] line_sel,
    input wire logic [7:0] hold_cyc,
    input wire logic ignore_wait,
    // Camera status
    input wire logic trig_wait,
    // Trigger lines
    output logic iso_line,
    output logic line_a,
    output logic line_b
);
    logic [7:0] cnt_ff = 8'h00;
    logic act;

    // ==========================================
    // Pulse timing
    // A pulse starts only while the camera reports ready, unless told to misbehave.
    always @(posedge core_clk) begin
        if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end else if (go && (trig_wait || ignore_wait)) begin
            cnt_ff <= hold_cyc;
        end
    end

    // Idle lines rest low, as with a pull-down.
    assign act = cnt_ff != 8'h00;
    assign iso_line = act && (line_sel == 2'h0);
    assign line_a = act && (line_sel == 2'h1);
    assign line_b = act && (line_sel == 2'h2);
endmodule

// File: dv/camera_trigger_io_control_tb.sv
// Self-checking bench for the camera trigger and status line block.
`timescale 1ns/1ps
module camera_trigger_io_control_tb;
    import cti_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0, ignore_wait = 1'b0;
    logic [1:0] line_sel = 2'h0;
    logic [7:0] hold_cyc = 8'h00;
    logic iso_in, general_line_a_in, general_line_b_in;
    logic dir_out_a = 1'b0, dir_out_b = 1'b0, edge_falling = 1'b0;
    logic [1:0] trig_src_sel = SRC_ISO;
    logic [DEB_W-1:0] debounce_us = DEB_RST;
    logic [DLY_W-1:0] delay_us = DLY_RST;
    cti_omode_t out_mode_iso = OM_WAIT, out_mode_a = OM_WAIT, out_mode_b = OM_WAIT;
    logic [2:0] user_value = 3'h0;
    logic sensor_exposing = 1'b0, readout_done = 1'b0, strobe_in = 1'b0;
    logic iso_out, general_line_a_out, general_line_a_oe_n;
    logic general_line_b_out, general_line_b_oe_n;
    logic capture_start, trig_wait, exposure_active, trig_ignored, delay_busy;
    int fails = 0, total_checks = 0, n_cap = 0, n_ign = 0, c0 = 0, i0 = 0;
    int dl[3] = '{0, 1, 3};

    // ==========================================
    // Clock, partner and design
    initial begin
        forever begin
            #25 core_clk = ~core_clk;
        end
    end

    always @(posedge core_clk) begin
        if (capture_start === 1'b1) n_cap <= n_cap + 1;
        if (trig_ignored === 1'b1) n_ign <= n_ign + 1;
    end

    cti_trig_src src (.core_clk(core_clk), .go(go), .line_sel(line_sel),
        .hold_cyc(hold_cyc), .ignore_wait(ignore_wait), .trig_wait(trig_wait),
        .iso_line(iso_in), .line_a(general_line_a_in), .line_b(general_line_b_in));

    cti_top dut (.core_clk(core_clk), .rst(rst), .iso_in(iso_in), .iso_out(iso_out),
        .general_line_a_in(general_line_a_in), .general_line_a_out(general_line_a_out),
        .general_line_a_oe_n(general_line_a_oe_n), .general_line_b_in(general_line_b_in),
        .general_line_b_out(general_line_b_out), .general_line_b_oe_n(general_line_b_oe_n),
        .dir_out_a(dir_out_a), .dir_out_b(dir_out_b), .trig_src_sel(trig_src_sel),
        .edge_falling(edge_falling), .debounce_us(debounce_us), .delay_us(delay_us),
        .out_mode_iso(out_mode_iso), .out_mode_a(out_mode_a), .out_mode_b(out_mode_b),
        .user_value(user_value), .sensor_exposing(sensor_exposing),
        .readout_done(readout_done), .strobe_in(strobe_in), .capture_start(capture_start),
        .trig_wait(trig_wait), .exposure_active(exposure_active),
        .trig_ignored(trig_ignored), .delay_busy(delay_busy));

    // ==========================================
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic fire(input logic [1:0] sel, input logic [7:0] hold, input logic ign);
        // The partner drops a request while it still drives a pulse.
        while (iso_in || general_line_a_in || general_line_b_in) cyc(1);
        line_sel = sel;
        hold_cyc = hold;
        ignore_wait = ign;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
    endtask

    // Counts cycles from the start of the delay to the capture pulse.
    task automatic trig_time(input int d);
        int k;
        int n;
        k = 0;
        n = 0;
        while (delay_busy !== 1'b1 && k < 400) begin
            cyc(1);
            k++;
        end
        while (capture_start !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        chk("delay cycles", 20 * d + 1, n);
        chk("ready low at capture", 0, trig_wait);
        chk("delay done", 0, delay_busy);
        cyc(1);
        chk("capture pulse end", 0, capture_start);
    endtask

    task automatic expose();
        sensor_exposing = 1'b1;
        cyc(1);
        chk("exposure on", 1, exposure_active);
        sensor_exposing = 1'b0;
        cyc(1);
        chk("exposure off", 0, exposure_active);
        chk("ready before readout", 0, trig_wait);
        readout_done = 1'b1;
        cyc(1);
        readout_done = 1'b0;
        chk("ready after readout", 1, trig_wait);
    endtask

    function automatic logic exp_out(input int m, input int v, input logic ub);
        if (m == 0) return 1'b1;
        if (m == 3) return ub;
        if (m == 2) return !v[0];
        return v[0];
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        #1000000;
        fails++;
        give_verdict();
    end

    // ==========================================
    // Tests
    initial begin
        cyc(4);
        chk("reset ready", 1, trig_wait);
        chk("reset oe a", 1, general_line_a_oe_n);
        chk("reset iso out", 0, iso_out);
        cyc(1);
        rst = 1'b0;
        cyc(2);
        $display("test reset done");
        foreach (dl[i]) begin
            delay_us = DLY_W'(dl[i]);
            fire(SRC_ISO, 8'h06, 1'b0);
            trig_time(dl[i]);
            expose();
        end
        $display("test delay done");
        delay_us = DLY_RST;
        debounce_us = 15'h0002;
        c0 = n_cap;
        fire(SRC_ISO, 8'h14, 1'b0);
        cyc(150);
        chk("short pulse", c0, n_cap);
        fire(SRC_ISO, 8'h50, 1'b0);
        trig_time(0);
        expose();
        debounce_us = DEB_RST;
        $display("test debounce done");
        // Let the long pulse fall before the edge polarity flips.
        while (iso_in !== 1'b0) cyc(1);
        cyc(2);
        edge_falling = 1'b1;
        c0 = n_cap;
        fire(SRC_ISO, 8'h1e, 1'b0);
        cyc(20);
        chk("no trigger on rise", c0, n_cap);
        chk("idle during pulse", 0, delay_busy);
        trig_time(0);
        expose();
        edge_falling = 1'b0;
        $display("test falling edge done");
        delay_us = 23'h000003;
        c0 = n_cap;
        i0 = n_ign;
        fire(SRC_ISO, 8'h06, 1'b0);
        cyc(20);
        fire(SRC_ISO, 8'h06, 1'b0);
        cyc(70);
        chk("capture once", c0 + 1, n_cap);
        chk("ignored in delay", i0 + 1, n_ign);
        fire(SRC_ISO, 8'h06, 1'b1);
        cyc(10);
        chk("ignored in busy", i0 + 2, n_ign);
        chk("no capture in busy", c0 + 1, n_cap);
        expose();
        $display("test ignore done");
        for (int s = 1; s < 3; s++) begin
            trig_src_sel = 2'(s);
            dir_out_a = (s == 1);
            dir_out_b = (s == 2);
            c0 = n_cap;
            fire(2'(s), 8'h06, 1'b0);
            cyc(80);
            chk("output line no trigger", c0, n_cap);
            dir_out_a = 1'b0;
            dir_out_b = 1'b0;
            cyc(2);
            fire(2'(s), 8'h06, 1'b0);
            trig_time(3);
            expose();
        end
        trig_src_sel = 2'h3;
        c0 = n_cap;
        fire(SRC_ISO, 8'h06, 1'b0);
        cyc(80);
        chk("no source selected", c0, n_cap);
        trig_src_sel = SRC_ISO;
        $display("test general inputs done");
        dir_out_a = 1'b1;
        dir_out_b = 1'b1;
        for (int m = 0; m < 4; m++) begin
            for (int v = 0; v < 2; v++) begin
                out_mode_iso = cti_omode_t'(2'(m));
                out_mode_a = cti_omode_t'(2'(m));
                out_mode_b = cti_omode_t'(2'(m));
                strobe_in = !v[0];
                sensor_exposing = v[0];
                user_value = 3'b101 ^ {3{v[0]}};
                cyc(3);
                chk("iso line", exp_out(m, v, user_value[0]), iso_out);
                chk("line a", exp_out(m, v, user_value[1]), general_line_a_out);
                chk("line b", exp_out(m, v, user_value[2]), general_line_b_out);
                chk("oe b", 0, general_line_b_oe_n);
                chk("oe a", 0, general_line_a_oe_n);
            end
        end
        sensor_exposing = 1'b0;
        strobe_in = 1'b0;
        dir_out_a = 1'b0;
        cyc(2);
        chk("input line out", 0, general_line_a_out);
        chk("input line oe", 1, general_line_a_oe_n);
        $display("test outputs done");
        give_verdict();
    end
endmodule
